/* File: common/ctcca_pkg.sv */
// Shared constants and types of the two-bit carry-chain adder slice.
// Assumes both ends and the bit stage import it; no clock or bus of its own.
package ctcca_pkg;
  // Default lookup word per half: sum = second ^ first ^ fourth input
  localparam logic [15:0] CTCCA_FUNC_WORD_DEFAULT = 16'hC33C;
  localparam int CTCCA_BITS = 2;
  localparam logic CTCCA_CONST_HIGH = 1'h1;
  localparam logic CTCCA_CONST_LOW = 1'h0;
  localparam logic CTCCA_MODE_SLICE = 1'h0;
  localparam logic CTCCA_MODE_CELL = 1'h1;

  typedef enum logic [2:0] {
    CTCCA_IDLE = 3'b000,
    CTCCA_APPLY = 3'b001,
    CTCCA_CHAIN = 3'b010,
    CTCCA_SETTLE = 3'b011,
    CTCCA_CAPTURE = 3'b100
  } ctcca_state_t;
endpackage : ctcca_pkg

/* File: common/ctcca_link_if.sv */
// Link between the adder slice and the fabric logic around it.
// Assumes one clock; the slice drives its signals from flip-flops, the fabric from flip-flops and tied-low spares.
`timescale 1ns/1ps
interface ctcca_link_if;
  // Fabric to slice
  logic spare_input_lo;
  logic spare_input_hi;
  logic first_operand_lo;
  logic first_operand_hi;
  logic second_operand_lo;
  logic second_operand_hi;
  logic third_operand_lo;
  logic third_operand_hi;
  logic slice_carry_in;
  logic bit0_carry_in;
  logic bit1_carry_in;
  // Slice to fabric
  logic sum_low;
  logic sum_high;
  logic slice_carry_out;
  logic bit0_carry_out;
  logic bit1_carry_out;

  modport dev (
    input spare_input_lo, spare_input_hi, first_operand_lo, first_operand_hi,
    input second_operand_lo, second_operand_hi, third_operand_lo, third_operand_hi,
    input slice_carry_in, bit0_carry_in, bit1_carry_in,
    output sum_low, sum_high, slice_carry_out, bit0_carry_out, bit1_carry_out
  );
  modport fab (
    output spare_input_lo, spare_input_hi, first_operand_lo, first_operand_hi,
    output second_operand_lo, second_operand_hi, third_operand_lo, third_operand_hi,
    output slice_carry_in, bit0_carry_in, bit1_carry_in,
    input sum_low, sum_high, slice_carry_out, bit0_carry_out, bit1_carry_out
  );
endinterface : ctcca_link_if

/* File: rtl/ctcca_bit_stage.sv */
// One bit position of the adder: lookup-word sum and majority carry.
// Assumes the caller picks the fourth lookup input and the incoming carry.
`timescale 1ns/1ps
module ctcca_bit_stage
  import ctcca_pkg::*;
(
  // Configuration
  input wire logic [15:0] func_word,
  // Bit inputs
  input wire logic spare,
  input wire logic op_first,
  input wire logic op_second,
  input wire logic lut_fourth,
  input wire logic carry_in,
  // Bit outputs
  output logic sum,
  output logic carry_out
);
  // Spare input is the lowest index bit; the default word ignores it
  always_comb begin
    sum = func_word[{lut_fourth, op_second, op_first, spare}];
    carry_out = (op_first & op_second) | (carry_in & (op_first ^ op_second));
  end
endmodule : ctcca_bit_stage

/* File: rtl/ctcca_slice_dev.sv */
// Adder slice end: two bit stages, chained or per-bit carry, registered.
// Assumes the fabric end keeps operands steady while results settle.
`timescale 1ns/1ps
module ctcca_slice_dev
  import ctcca_pkg::*;
#(
  parameter logic [15:0] LOWER_HALF_FUNCTION_WORD = CTCCA_FUNC_WORD_DEFAULT,
  parameter logic [15:0] UPPER_HALF_FUNCTION_WORD = CTCCA_FUNC_WORD_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Variant select: slice or full-adder cell
  input wire logic cell_mode,
  // Link
  ctcca_link_if.dev link
);
  typedef struct packed {
    logic sum_low;
    logic sum_high;
    logic slice_carry_out;
    logic bit0_carry_out;
    logic bit1_carry_out;
  } ctcca_dev_t;

  ctcca_dev_t st_r;
  ctcca_dev_t st_nxt;
  logic [CTCCA_BITS-1:0] spare_w;
  logic [CTCCA_BITS-1:0] first_w;
  logic [CTCCA_BITS-1:0] second_w;
  logic [CTCCA_BITS-1:0] third_w;
  logic [CTCCA_BITS-1:0] cin_w;
  logic [CTCCA_BITS-1:0] fourth_w;
  logic [CTCCA_BITS-1:0] sum_w;
  logic [CTCCA_BITS-1:0] slice_carry_out_w;
  logic [CTCCA_BITS*16-1:0] words_w;

  assign spare_w = {link.spare_input_hi, link.spare_input_lo};
  assign first_w = {link.first_operand_hi, link.first_operand_lo};
  assign second_w = {link.second_operand_hi, link.second_operand_lo};
  assign third_w = {link.third_operand_hi, link.third_operand_lo};
  assign words_w = {UPPER_HALF_FUNCTION_WORD, LOWER_HALF_FUNCTION_WORD};

  // Slice chains bit 0 into bit 1 inside; the cell takes both carries in
  assign cin_w[0] = cell_mode ? link.bit0_carry_in : link.slice_carry_in;
  assign cin_w[1] = cell_mode ? link.bit1_carry_in : slice_carry_out_w[0];

  genvar gi;
  generate
    for (gi = 0; gi < CTCCA_BITS; gi++) begin : g_bit
      // Cell sums over its third operand; the slice sums over the carry
      assign fourth_w[gi] = cell_mode ? third_w[gi] : cin_w[gi];
      ctcca_bit_stage u_stage (
        .func_word(words_w[gi*16 +: 16]),
        .spare(spare_w[gi]),
        .op_first(first_w[gi]),
        .op_second(second_w[gi]),
        .lut_fourth(fourth_w[gi]),
        .carry_in(cin_w[gi]),
        .sum(sum_w[gi]),
        .carry_out(slice_carry_out_w[gi])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.sum_low = sum_w[0];
    st_nxt.sum_high = sum_w[1];
    st_nxt.slice_carry_out = slice_carry_out_w[1];
    st_nxt.bit0_carry_out = slice_carry_out_w[0];
    st_nxt.bit1_carry_out = slice_carry_out_w[1];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sum_low = st_r.sum_low;
  assign link.sum_high = st_r.sum_high;
  assign link.slice_carry_out = st_r.slice_carry_out;
  assign link.bit0_carry_out = st_r.bit0_carry_out;
  assign link.bit1_carry_out = st_r.bit1_carry_out;
endmodule : ctcca_slice_dev

/* File: rtl/ctcca_fabric_end.sv */
// Fabric end: seeds the chain, routes carries and captures the result.
// Assumes the slice end registers its outputs one edge after its inputs.
`timescale 1ns/1ps
module ctcca_fabric_end
  import ctcca_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User request
  input wire logic cell_mode,
  input wire logic add_req,
  input wire logic carry_seed,
  input wire logic [1:0] op_a,
  input wire logic [1:0] op_b,
  // User result
  output logic busy,
  output logic done,
  output logic [1:0] result_sum,
  output logic result_carry,
  // Link
  ctcca_link_if.fab link
);
  typedef struct packed {
    ctcca_state_t state;
    logic [1:0] first;
    logic [1:0] second;
    logic [1:0] third;
    logic slice_cin;
    logic b0_cin;
    logic b1_cin;
    logic busy;
    logic done;
    logic [1:0] sum;
    logic carry;
  } ctcca_fab_t;

  ctcca_fab_t st_r;
  ctcca_fab_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'h0;
    case (st_r.state)
      CTCCA_IDLE: begin
        if (add_req) begin
          st_nxt.busy = 1'h1;
          st_nxt.state = CTCCA_APPLY;
          // Open carry input modelled as the level the tools force
          st_nxt.slice_cin = CTCCA_CONST_LOW;
          st_nxt.b1_cin = CTCCA_CONST_LOW;
          if (cell_mode && carry_seed) begin
            st_nxt.b0_cin = CTCCA_CONST_HIGH;
            st_nxt.first = op_a;
            st_nxt.second = op_b;
            st_nxt.third = {CTCCA_CONST_LOW, CTCCA_CONST_HIGH};
          end else begin
            // Burn bit 0 so it hands the seed to bit 1; an open cell carry-in
            // is forced high, and the grounded pair still passes a low carry
            st_nxt.b0_cin = CTCCA_CONST_HIGH;
            st_nxt.first = {op_a[1], carry_seed};
            st_nxt.second = {op_b[1], carry_seed};
            st_nxt.third = {CTCCA_CONST_LOW, CTCCA_CONST_LOW};
          end
        end
      end
      CTCCA_APPLY: begin
        st_nxt.state = CTCCA_CHAIN;
      end
      CTCCA_CHAIN: begin
        // Bit 0 carry goes to the next carry input and to the high third operand
        st_nxt.b1_cin = link.bit0_carry_out;
        st_nxt.third[1] = link.bit0_carry_out;
        st_nxt.state = CTCCA_SETTLE;
      end
      CTCCA_SETTLE: begin
        st_nxt.state = CTCCA_CAPTURE;
      end
      CTCCA_CAPTURE: begin
        // Register plays the pass-through stage above the carry
        st_nxt.sum = {link.sum_high, link.sum_low};
        st_nxt.carry = cell_mode ? link.bit1_carry_out : link.slice_carry_out;
        st_nxt.done = 1'h1;
        st_nxt.busy = 1'h0;
        st_nxt.state = CTCCA_IDLE;
      end
      default: begin
        st_nxt.state = CTCCA_IDLE;
        st_nxt.busy = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Spare inputs stay low: they take no part in the sum
  assign link.spare_input_lo = CTCCA_CONST_LOW;
  assign link.spare_input_hi = CTCCA_CONST_LOW;
  assign link.first_operand_lo = st_r.first[0];
  assign link.first_operand_hi = st_r.first[1];
  assign link.second_operand_lo = st_r.second[0];
  assign link.second_operand_hi = st_r.second[1];
  assign link.third_operand_lo = st_r.third[0];
  assign link.third_operand_hi = st_r.third[1];
  assign link.slice_carry_in = st_r.slice_cin;
  assign link.bit0_carry_in = st_r.b0_cin;
  assign link.bit1_carry_in = st_r.b1_cin;
  assign busy = st_r.busy;
  assign done = st_r.done;
  assign result_sum = st_r.sum;
  assign result_carry = st_r.carry;
endmodule : ctcca_fabric_end

/* File: bench/ctcca_asserts.sv */
// Link checker for the two-bit adder slice with default function words.
// Assumes one clock and slice outputs registered one edge behind inputs.
`timescale 1ns/1ps
module ctcca_asserts (
  // Clock, reset, variant
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cell_mode,
  // Fabric to slice
  input wire logic spare_input_lo,
  input wire logic spare_input_hi,
  input wire logic first_operand_lo,
  input wire logic first_operand_hi,
  input wire logic second_operand_lo,
  input wire logic second_operand_hi,
  input wire logic third_operand_lo,
  input wire logic third_operand_hi,
  input wire logic slice_carry_in,
  input wire logic bit0_carry_in,
  input wire logic bit1_carry_in,
  // Slice to fabric
  input wire logic sum_low,
  input wire logic sum_high,
  input wire logic slice_carry_out,
  input wire logic bit0_carry_out,
  input wire logic bit1_carry_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic x0, x1, g1, p1, c0, d0, d1, e0, k0;
  assign x0 = first_operand_lo ^ second_operand_lo;
  assign x1 = first_operand_hi ^ second_operand_hi;
  assign g1 = first_operand_hi & second_operand_hi;
  assign p1 = first_operand_hi | second_operand_hi;
  // Slice mode chains bit 0 carry inside; cell mode sums with third operands
  assign c0 = first_operand_lo & second_operand_lo | slice_carry_in & (first_operand_lo | second_operand_lo);
  assign d0 = cell_mode ? third_operand_lo : slice_carry_in;
  assign d1 = cell_mode ? third_operand_hi : c0;
  // Bit 0 carry takes the slice or the cell carry-in by variant
  assign e0 = cell_mode ? bit0_carry_in : slice_carry_in;
  assign k0 = first_operand_lo & second_operand_lo | e0 & (first_operand_lo | second_operand_lo);
  sum_low_a: assert property (!$past(sys_rst) |-> sum_low == $past(x0 ^ d0))
    else $error("low sum wrong");
  sum_high_a: assert property (!$past(sys_rst) |-> sum_high == $past(x1 ^ d1))
    else $error("high sum wrong");
  chain_carry_a: assert property (!$past(sys_rst) && !$past(cell_mode) |-> slice_carry_out == $past(g1 | p1 & c0))
    else $error("slice carry wrong");
  cell_carry_a: assert property (!$past(sys_rst) && $past(cell_mode) |-> bit1_carry_out == $past(g1 | p1 & bit1_carry_in))
    else $error("cell carry wrong");
  low_carry_a: assert property (!$past(sys_rst) |-> bit0_carry_out == $past(k0))
    else $error("bit 0 carry wrong");
  same_word_a: assert property (!$past(sys_rst) && $past(x0 == x1 && d0 == d1) |-> sum_low == sum_high)
    else $error("halves differ");
  spare_low_a: assert property (spare_input_lo == 1'h0 && spare_input_hi == 1'h0)
    else $error("spare input high");
  burn_pair_a: assert property (!cell_mode |-> first_operand_lo == second_operand_lo)
    else $error("burned half split");
  open_cin_a: assert property (slice_carry_in == 1'h0)
    else $error("open carry driven");
  cover property (!cell_mode && slice_carry_out);
  cover property (cell_mode && bit1_carry_out && sum_high);
  cover property (cell_mode && third_operand_lo);
  cover property (cell_mode && bit0_carry_in && !bit0_carry_out);
endmodule : ctcca_asserts

/* File: bench/tb_two_bit_carry_chain_adder.sv */
// Self-checking bench: fabric end and adder slice joined over the link.
// Assumes a 40 MHz clock; user inputs change 2 ns after each edge.
`timescale 1ns/1ps
module tb_two_bit_carry_chain_adder;
  import ctcca_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cell_mode = 1'h0;
  logic add_req = 1'h0;
  logic carry_seed = 1'h0;
  logic [1:0] op_a = 2'h0;
  logic [1:0] op_b = 2'h0;
  logic busy, done, result_carry;
  logic [1:0] result_sum;
  int mismatches = 0;
  int checks = 0;
  ctcca_link_if link ();
  ctcca_slice_dev u_ctcca_slice_dev (.clk, .sys_rst, .cell_mode, .link);
  ctcca_fabric_end u_ctcca_fabric_end (.clk, .sys_rst, .cell_mode, .add_req, .carry_seed, .op_a, .op_b, .busy,
    .done, .result_sum, .result_carry, .link);
  ctcca_asserts u_ctcca_asserts (.clk, .sys_rst, .cell_mode, .spare_input_lo(link.spare_input_lo),
    .spare_input_hi(link.spare_input_hi), .first_operand_lo(link.first_operand_lo),
    .first_operand_hi(link.first_operand_hi), .second_operand_lo(link.second_operand_lo),
    .second_operand_hi(link.second_operand_hi), .third_operand_lo(link.third_operand_lo),
    .third_operand_hi(link.third_operand_hi), .slice_carry_in(link.slice_carry_in),
    .bit0_carry_in(link.bit0_carry_in), .bit1_carry_in(link.bit1_carry_in),
    .sum_low(link.sum_low), .sum_high(link.sum_high), .slice_carry_out(link.slice_carry_out),
    .bit0_carry_out(link.bit0_carry_out), .bit1_carry_out(link.bit1_carry_out));

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #2;
      n++;
    end while (done !== 1'h1 && n < 20);
    check(n < 20, "no done");
    if (n >= 20) results();
  endtask : wait_done

  // Twice keeps the request up, so it must be ignored while busy
  task automatic add_once(input logic mode, input logic seed, input logic [1:0] a, input logic [1:0] b,
    input logic twice);
    logic [2:0] want;
    int n;
    @(posedge clk);
    #2;
    {cell_mode, carry_seed, op_a, op_b, add_req} = {mode, seed, a, b, 1'h1};
    wait_done(n);
    if (twice) wait_done(n);
    add_req = 1'h0;
    // Only the cell with a high seed adds bit 0 for real
    want = (mode & seed) ? {1'h0, a} + {1'h0, b} + 3'h1 : {1'h0, a[1], 1'h0} + {1'h0, b[1], 1'h0} + {1'h0, seed, 1'h0};
    check(n == 5 && busy === 1'h0, "done timing");
    check(result_sum[1] === want[1] && result_carry === want[2], "sum or carry");
    check(!(mode & seed) || result_sum[0] === want[0], "low sum");
    // Done is a one-cycle pulse; the captured carry must stand after it
    @(posedge clk);
    #2;
    check(done === 1'h0 && result_carry === want[2], "done held");
  endtask : add_once

  initial begin
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (8) @(posedge clk);
    #2;
    sys_rst = 1'h0;
    check(done === 1'h0 && busy === 1'h0 && result_sum === 2'h0, "reset outputs");
    add_once(1'h0, 1'h0, 2'h3, 2'h1, 1'h0);
    add_once(1'h0, 1'h1, 2'h2, 2'h2, 1'h1);
    add_once(1'h0, 1'h1, 2'h1, 2'h0, 1'h0);
    add_once(1'h1, 1'h1, 2'h3, 2'h3, 1'h0);
    add_once(1'h1, 1'h1, 2'h0, 2'h1, 1'h0);
    add_once(1'h1, 1'h0, 2'h2, 2'h3, 1'h0);
    results();
  end
endmodule : tb_two_bit_carry_chain_adder
